//--- hdl/card_xfer.sv
/*
 Card transfer sequencer: APB register file, command issue with response
 capture, block buffer paced by ready flags, block counting and SDMA
 boundary stops.
 Assumes link_clk, card_rdata and card_rvalid come from the card domain;
 the card holds card_rdata/card_rvalid stable around each link_clk rise.
*/
`timescale 1ns/1ps
`default_nettype none
module card_xfer #(
   parameter int buf_words = 128
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_clk,
   input wire logic [31:0] card_rdata,
   input wire logic card_rvalid,
   output logic [31:0] card_wdata,
   output logic card_wvalid,
   output logic card_cmd_valid,
   output logic [5:0] card_cmd_index,
   output logic [31:0] card_cmd_arg,
   output logic [31:0] host_ctrl
);
   localparam int pw = $clog2(buf_words);
   logic [31:0] mem [buf_words];
   logic [31:0] sys_lo_q, sys_lo_d, sys_hi_q, sys_hi_d, blk_q, blk_d;
   logic [31:0] arg_q, arg_d, cmd_q, cmd_d, hc_q, hc_d, idl_q, idl_d;
   logic [31:0] idh_q, idh_d, rdat_q, rdat_d, wdat_q, wdat_d;
   logic [31:0] resp_q [card_xfer_pkg::resp_words];
   logic [31:0] resp_d [card_xfer_pkg::resp_words];
   logic [5:0] st_flags_q, st_flags_d;
   logic [15:0] left_q, left_d;
   logic [pw-1:0] ptr_q, ptr_d;
   logic [1:0] ridx_q, ridx_d;
   card_xfer_pkg::state_t st_q, st_d;
   logic rdy_q, rdy_d, err_q, err_d, wv_q, wv_d, cv_q, cv_d;
   logic lk1_q, lk2_q, lk3_q, rv1_q, rv2_q;
   logic [31:0] rd1_q, rd2_q;
   logic mem_we;
   logic [pw-1:0] mem_wa;
   logic [31:0] mem_wd;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // Data and valid through two flip-flops, link clock through three; edge found on the second stage
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lk1_q <= 1'b0;
         lk2_q <= 1'b0;
         lk3_q <= 1'b0;
         rv1_q <= 1'b0;
         rv2_q <= 1'b0;
         rd1_q <= card_xfer_pkg::reg_reset;
         rd2_q <= card_xfer_pkg::reg_reset;
      end else begin
         lk1_q <= link_clk;
         lk2_q <= lk1_q;
         lk3_q <= lk2_q;
         rv1_q <= card_rvalid;
         rv2_q <= rv1_q;
         rd1_q <= card_rdata;
         rd2_q <= rd1_q;
      end
   end

   logic link_edge, acc, wr, rd, last_word, last_blk, dma, is_rd;
   logic [pw-1:0] words;
   logic [5:0] flag_set, flag_clr;
   always_comb begin
      link_edge = lk2_q & ~lk3_q;
      acc = psel & penable & rdy_q;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
      words = (blk_q[11:2] == 10'h000) ? pw'(1) : pw'(blk_q[11:2]);
      last_word = (ptr_q == words - pw'(1));
      last_blk = ~cmd_q[card_xfer_pkg::multi_block_bit] |
                 (left_q == 16'h0001);
      dma = cmd_q[card_xfer_pkg::dma_enable_bit];
      is_rd = cmd_q[card_xfer_pkg::direction_bit];
   end

   always_comb begin
      sys_lo_d = sys_lo_q;
      sys_hi_d = sys_hi_q;
      blk_d = blk_q;
      arg_d = arg_q;
      cmd_d = cmd_q;
      hc_d = hc_q;
      idl_d = idl_q;
      idh_d = idh_q;
      wdat_d = wdat_q;
      resp_d = resp_q;
      left_d = left_q;
      ptr_d = ptr_q;
      ridx_d = ridx_q;
      st_d = st_q;
      wv_d = 1'b0;
      cv_d = 1'b0;
      flag_set = 6'h00;
      flag_clr = 6'h00;
      mem_we = 1'b0;
      mem_wa = ptr_q;
      mem_wd = pwdata;
      // One wait state: ready in the cycle after the access phase opens
      rdy_d = psel & penable & ~rdy_q;
      err_d = 1'b0;
      rdat_d = 32'h0000_0000;
      if (psel & penable & ~rdy_q & ~pwrite) begin
         if (hit(paddr, card_xfer_pkg::sys_addr_low_off)) begin
            rdat_d = sys_lo_q;
         end else if (hit(paddr, card_xfer_pkg::block_off)) begin
            rdat_d = blk_q;
         end else if (hit(paddr, card_xfer_pkg::argument_off)) begin
            rdat_d = arg_q;
         end else if (hit(paddr, card_xfer_pkg::command_off)) begin
            rdat_d = cmd_q;
         end else if (paddr >= card_xfer_pkg::resp0_off &&
                      paddr <= card_xfer_pkg::resp3_off &&
                      paddr[1:0] == 2'b00) begin
            rdat_d = resp_q[paddr[3:2]];
         end else if (hit(paddr, card_xfer_pkg::buffer_off)) begin
            rdat_d = mem[ptr_q];
         end else if (hit(paddr, card_xfer_pkg::present_off)) begin
            rdat_d = {29'h0000_0000, st_q};
         end else if (hit(paddr, card_xfer_pkg::host_ctrl_off)) begin
            rdat_d = hc_q;
         end else if (hit(paddr, card_xfer_pkg::int_status_off)) begin
            rdat_d = {26'h000_0000, st_flags_q};
         end else if (hit(paddr, card_xfer_pkg::sys_addr_high_off)) begin
            rdat_d = sys_hi_q;
         end else if (hit(paddr, card_xfer_pkg::id_addr_low_off)) begin
            rdat_d = idl_q;
         end else if (hit(paddr, card_xfer_pkg::id_addr_high_off)) begin
            rdat_d = idh_q;
         end else begin
            err_d = 1'b1;
         end
      end
      if (psel & penable & ~rdy_q & pwrite &&
          !(hit(paddr, card_xfer_pkg::sys_addr_low_off) ||
            hit(paddr, card_xfer_pkg::block_off) ||
            hit(paddr, card_xfer_pkg::argument_off) ||
            hit(paddr, card_xfer_pkg::command_off) ||
            hit(paddr, card_xfer_pkg::buffer_off) ||
            hit(paddr, card_xfer_pkg::host_ctrl_off) ||
            hit(paddr, card_xfer_pkg::int_status_off) ||
            hit(paddr, card_xfer_pkg::sys_addr_high_off) ||
            hit(paddr, card_xfer_pkg::id_addr_low_off) ||
            hit(paddr, card_xfer_pkg::id_addr_high_off))) begin
         err_d = 1'b1;
      end
      if (wr) begin
         if (hit(paddr, card_xfer_pkg::sys_addr_low_off)) begin
            sys_lo_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::block_off)) begin
            blk_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::argument_off)) begin
            arg_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::host_ctrl_off)) begin
            hc_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::int_status_off)) begin
            flag_clr = pwdata[5:0];
         end else if (hit(paddr, card_xfer_pkg::sys_addr_high_off)) begin
            sys_hi_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::id_addr_low_off)) begin
            idl_d = pwdata;
         end else if (hit(paddr, card_xfer_pkg::id_addr_high_off)) begin
            idh_d = pwdata;
         end
      end
      case (st_q)
         card_xfer_pkg::st_idle: begin
            // Command and transfer mode taken in one word write
            if (wr && hit(paddr, card_xfer_pkg::command_off)) begin
               cmd_d = pwdata;
               left_d = blk_q[31:16];
               cv_d = 1'b1;
               ridx_d = 2'd0;
               st_d = card_xfer_pkg::st_cmd;
            end
         end
         card_xfer_pkg::st_cmd: begin
            if (link_edge & rv2_q) begin
               resp_d[ridx_q] = rd2_q;
               ridx_d = ridx_q + 2'd1;
               if (ridx_q == 2'd3) begin
                  flag_set[card_xfer_pkg::cmd_done_bit] = 1'b1;
                  ptr_d = '0;
                  if (!cmd_q[card_xfer_pkg::data_present_bit]) begin
                     st_d = card_xfer_pkg::st_idle;
                  end else if (is_rd) begin
                     st_d = card_xfer_pkg::st_rd_recv;
                  end else begin
                     st_d = card_xfer_pkg::st_wr_fill;
                     flag_set[card_xfer_pkg::wr_ready_bit] = ~dma;
                  end
               end
            end
         end
         card_xfer_pkg::st_wr_fill: begin
            if (dma) begin
               st_d = card_xfer_pkg::st_wr_send;
            end else if (wr && hit(paddr, card_xfer_pkg::buffer_off)) begin
               mem_we = 1'b1;
               ptr_d = last_word ? '0 : ptr_q + pw'(1);
               if (last_word) begin
                  st_d = card_xfer_pkg::st_wr_send;
               end
            end
         end
         card_xfer_pkg::st_wr_send: begin
            if (link_edge) begin
               wdat_d = mem[ptr_q];
               wv_d = 1'b1;
               ptr_d = last_word ? '0 : ptr_q + pw'(1);
            end
         end
         card_xfer_pkg::st_rd_recv: begin
            if (link_edge & rv2_q) begin
               mem_we = 1'b1;
               mem_wd = rd2_q;
               ptr_d = last_word ? '0 : ptr_q + pw'(1);
               if (last_word && !dma) begin
                  st_d = card_xfer_pkg::st_rd_drain;
                  flag_set[card_xfer_pkg::rd_ready_bit] = 1'b1;
               end
            end
         end
         card_xfer_pkg::st_rd_drain: begin
            if (rd && hit(paddr, card_xfer_pkg::buffer_off)) begin
               ptr_d = last_word ? '0 : ptr_q + pw'(1);
            end
         end
         card_xfer_pkg::st_dma_wait: begin
            // Next SDMA block waits for the address reload
            if (wr && hit(paddr, card_xfer_pkg::sys_addr_low_off)) begin
               st_d = is_rd ? card_xfer_pkg::st_rd_recv
                            : card_xfer_pkg::st_wr_send;
            end
         end
         default: st_d = card_xfer_pkg::st_idle;
      endcase
      // Block boundary
      if (last_word &&
          ((st_q == card_xfer_pkg::st_wr_send && link_edge) ||
           (st_q == card_xfer_pkg::st_rd_recv && link_edge && rv2_q && dma) ||
           (st_q == card_xfer_pkg::st_rd_drain && rd &&
            hit(paddr, card_xfer_pkg::buffer_off)))) begin
         left_d = left_q - 16'h0001;
         if (cmd_q[card_xfer_pkg::count_enable_bit]) begin
            blk_d[31:16] = blk_q[31:16] - 16'h0001;
         end
         if (last_blk) begin
            flag_set[card_xfer_pkg::xfer_done_bit] = 1'b1;
            st_d = card_xfer_pkg::st_idle;
         end else if (dma && hc_q[card_xfer_pkg::dma_sel_lsb +: 2] ==
                      card_xfer_pkg::dma_sel_sdma) begin
            flag_set[card_xfer_pkg::dma_int_bit] = 1'b1;
            st_d = card_xfer_pkg::st_dma_wait;
         end else if (is_rd) begin
            st_d = card_xfer_pkg::st_rd_recv;
         end else begin
            st_d = card_xfer_pkg::st_wr_fill;
            flag_set[card_xfer_pkg::wr_ready_bit] = ~dma;
         end
      end
      // A set in the clearing cycle wins
      st_flags_d = (st_flags_q & ~flag_clr) | flag_set;
   end

   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sys_lo_q <= card_xfer_pkg::reg_reset;
         sys_hi_q <= card_xfer_pkg::reg_reset;
         blk_q <= card_xfer_pkg::reg_reset;
         arg_q <= card_xfer_pkg::reg_reset;
         cmd_q <= card_xfer_pkg::reg_reset;
         hc_q <= card_xfer_pkg::reg_reset;
         idl_q <= card_xfer_pkg::reg_reset;
         idh_q <= card_xfer_pkg::reg_reset;
         rdat_q <= card_xfer_pkg::reg_reset;
         wdat_q <= card_xfer_pkg::reg_reset;
         for (int i = 0; i < card_xfer_pkg::resp_words; i++) begin
            resp_q[i] <= card_xfer_pkg::reg_reset;
         end
         st_flags_q <= 6'h00;
         left_q <= 16'h0000;
         ptr_q <= '0;
         ridx_q <= 2'd0;
         st_q <= card_xfer_pkg::st_idle;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         wv_q <= 1'b0;
         cv_q <= 1'b0;
      end else begin
         sys_lo_q <= sys_lo_d;
         sys_hi_q <= sys_hi_d;
         blk_q <= blk_d;
         arg_q <= arg_d;
         cmd_q <= cmd_d;
         hc_q <= hc_d;
         idl_q <= idl_d;
         idh_q <= idh_d;
         rdat_q <= rdat_d;
         wdat_q <= wdat_d;
         resp_q <= resp_d;
         st_flags_q <= st_flags_d;
         left_q <= left_d;
         ptr_q <= ptr_d;
         ridx_q <= ridx_d;
         st_q <= st_d;
         rdy_q <= rdy_d;
         err_q <= err_d;
         wv_q <= wv_d;
         cv_q <= cv_d;
      end
   end

   assign prdata = rdat_q;
   assign pready = rdy_q;
   assign pslverr = err_q;
   assign card_wdata = wdat_q;
   assign card_wvalid = wv_q;
   assign card_cmd_valid = cv_q;
   assign card_cmd_index = cmd_q[card_xfer_pkg::cmd_index_lsb +: 6];
   assign card_cmd_arg = arg_q;
   assign host_ctrl = hc_q;

   cmd_issue_a: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == card_xfer_pkg::st_idle && wr &&
      hit(paddr, card_xfer_pkg::command_off) |=> cv_q && cmd_q == $past(pwdata))
      else $error("command word not taken");
   resp_done_a: assert property (@(posedge ref_clk) disable iff (rst)
      st_q == card_xfer_pkg::st_cmd && link_edge && rv2_q && ridx_q == 2'd3
      |=> st_flags_q[card_xfer_pkg::cmd_done_bit] && resp_q[3] == $past(rd2_q))
      else $error("response not stored");
   wr_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_flags_q[card_xfer_pkg::wr_ready_bit]) |->
      st_q == card_xfer_pkg::st_wr_fill && ptr_q == '0)
      else $error("write ready outside fill");
   rd_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_flags_q[card_xfer_pkg::rd_ready_bit]) |->
      st_q == card_xfer_pkg::st_rd_drain)
      else $error("read ready outside drain");
   flag_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      wr && hit(paddr, card_xfer_pkg::int_status_off) && flag_set == 6'h00
      |=> (st_flags_q & $past(pwdata[5:0])) == 6'h00)
      else $error("flag not cleared by one");
   set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
      |flag_set |=> (st_flags_q & $past(flag_set)) == $past(flag_set))
      else $error("set lost");
   done_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_flags_q[card_xfer_pkg::xfer_done_bit]) |->
      st_q == card_xfer_pkg::st_idle)
      else $error("done without idle");
   count_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
      left_q != $past(left_q) && $past(st_q) != card_xfer_pkg::st_idle |->
      left_q == $past(left_q) - 16'h0001)
      else $error("block count step wrong");
   sdma_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(st_flags_q[card_xfer_pkg::dma_int_bit]) |->
      st_q == card_xfer_pkg::st_dma_wait)
      else $error("dma interrupt without stop");
endmodule : card_xfer
`default_nettype wire

//--- hdl/card_xfer_pkg.sv
/*
 Constants for the card transfer sequencer: register byte offsets, field
 positions, reset values and state encoding.
 Assumes a 32-bit APB master and a memory card sitting on the link pins.
*/
// Behaviour
// - Write-ready per block, cleared, buffer filled
// - Read-ready per block, cleared, buffer drained
// - Transfer-done flag set at end, software clears
// - SDMA raises DMA interrupt or transfer done
// - Response shown in four response registers
package card_xfer_pkg;
   localparam logic [7:0] sys_addr_low_off = 8'h00;
   localparam logic [7:0] block_off = 8'h04;
   localparam logic [7:0] argument_off = 8'h08;
   localparam logic [7:0] command_off = 8'h0C;
   localparam logic [7:0] resp0_off = 8'h10;
   localparam logic [7:0] resp3_off = 8'h1C;
   localparam logic [7:0] buffer_off = 8'h20;
   localparam logic [7:0] present_off = 8'h24;
   localparam logic [7:0] host_ctrl_off = 8'h28;
   localparam logic [7:0] int_status_off = 8'h30;
   localparam logic [7:0] sys_addr_high_off = 8'h58;
   localparam logic [7:0] id_addr_low_off = 8'h78;
   localparam logic [7:0] id_addr_high_off = 8'h7C;
   // Transfer mode field (low half of command word)
   localparam int dma_enable_bit = 0;
   localparam int count_enable_bit = 1;
   localparam int direction_bit = 4;
   localparam int multi_block_bit = 5;
   // Command field (high half of command word)
   localparam int data_present_bit = 21;
   localparam int cmd_index_lsb = 24;
   // Host control fields
   localparam int four_bit_bit = 1;
   localparam int high_speed_bit = 2;
   localparam int dma_sel_lsb = 3;
   localparam int wide_bus_bit = 5;
   localparam int mode_sel_lsb = 16;
   // Status flags
   localparam int cmd_done_bit = 0;
   localparam int xfer_done_bit = 1;
   localparam int dma_int_bit = 3;
   localparam int wr_ready_bit = 4;
   localparam int rd_ready_bit = 5;
   localparam logic [31:0] reg_reset = 32'h0000_0000;
   localparam logic [1:0] dma_sel_sdma = 2'h0;
   localparam int resp_words = 4;
   typedef enum logic [2:0] {
      st_idle, st_cmd, st_wr_fill, st_wr_send, st_rd_recv, st_rd_drain,
      st_dma_wait
   } state_t;
endpackage : card_xfer_pkg

//--- tb/card_model.sv
/*
 Memory card stand-in for the transfer sequencer bench: link clock, response
 and read words.
 Assumes the bench gates the link with run and clears the word count with
 restart before each command.
*/
`timescale 1ns/1ps
`default_nettype none
module card_model #(
   parameter logic [31:0] pat = 32'hC0DE_0000
) (
   input wire logic run,
   input wire logic restart,
   input wire logic rvalid_en,
   output logic link_clk,
   output logic [31:0] card_rdata,
   output logic card_rvalid
);
   logic [31:0] cnt;
   logic took;
   initial link_clk = 1'b0;
   // Link clock stands still outside frames
   always #32 link_clk = run ? ~link_clk : 1'b0;
   // Word n of each frame is pat + n: responses first, then data
   always @(posedge link_clk or posedge restart) begin
      if (restart) took <= 1'b0;
      else took <= rvalid_en;
   end
   // Advance on the falling edge so words stay stable around each rise
   always @(negedge link_clk or posedge restart) begin
      if (restart) cnt <= 32'h0000_0000;
      else if (took) cnt <= cnt + 32'h0000_0001;
   end
   assign card_rvalid = rvalid_en;
   // Idle words carry the inverse so stale data never looks valid
   assign card_rdata = rvalid_en ? pat + cnt : ~(pat + cnt);
endmodule : card_model
`default_nettype wire

//--- tb/card_xfer_tb.sv
/*
 Self-checking bench for the card transfer sequencer: registers, command
 issue, block write, block read and SDMA boundary stops.
 Assumes the card model in card_model.sv and the design package offsets.
*/
`timescale 1ns/1ps
`default_nettype none
module card_xfer_tb;
   localparam logic [31:0] pat = 32'hC0DE_0000;
   localparam logic [7:0] st = card_xfer_pkg::int_status_off;
   localparam logic [7:0] bk = card_xfer_pkg::block_off;
   localparam logic [7:0] bf = card_xfer_pkg::buffer_off;
   logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, card_rdata, card_wdata, card_cmd_arg;
   logic [31:0] host_ctrl, q;
   logic link_clk, card_rvalid, card_wvalid, card_cmd_valid;
   logic run, restart, rv_en, e;
   logic [5:0] card_cmd_index, idx_seen;
   logic [31:0] wq[$];
   int err_total, n_checks, cycles, cmd_seen;
   card_xfer #(.buf_words(128)) dut (.ref_clk(ref_clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_clk(link_clk), .card_rdata(card_rdata),
      .card_rvalid(card_rvalid), .card_wdata(card_wdata),
      .card_wvalid(card_wvalid), .card_cmd_valid(card_cmd_valid),
      .card_cmd_index(card_cmd_index), .card_cmd_arg(card_cmd_arg),
      .host_ctrl(host_ctrl));
   card_model #(.pat(pat)) card (.run(run), .restart(restart),
      .rvalid_en(rv_en), .link_clk(link_clk), .card_rdata(card_rdata),
      .card_rvalid(card_rvalid));
   always #4 ref_clk = ~ref_clk;
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // Watch the card side and cut a hang short
   always @(posedge ref_clk) begin
      cycles++;
      if (card_wvalid === 1'b1) wq.push_back(card_wdata);
      if (card_cmd_valid === 1'b1) begin
         cmd_seen++;
         idx_seen = card_cmd_index;
      end
      if (cycles == 40000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // Loops until pready; only the bench timeout ends a hang here
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      do begin apb(1'b0, st, 32'h0); n++; end while (q[b] !== 1'b1 && n < 500);
      chk({31'h0, q[b]}, 32'h1);
      apb(1'b1, st, 32'h1 << b);
   endtask : wait_flag
   function automatic logic [15:0] mode(input logic dma, input logic cnt,
         input logic dir, input logic multi);
      logic [15:0] m;
      m = 16'h0000;
      m[card_xfer_pkg::dma_enable_bit] = dma;
      m[card_xfer_pkg::count_enable_bit] = cnt;
      m[card_xfer_pkg::direction_bit] = dir;
      m[card_xfer_pkg::multi_block_bit] = multi;
      return m;
   endfunction : mode
   // One atomic word carries command and transfer mode
   task automatic issue(input logic [5:0] idx, input logic [15:0] m,
         input logic dat, input logic [31:0] arg);
      run <= 1'b0;
      rv_en <= 1'b1;
      restart <= 1'b1;
      @(posedge ref_clk);
      restart <= 1'b0;
      apb(1'b1, card_xfer_pkg::argument_off, arg);
      apb(1'b1, card_xfer_pkg::command_off,
         (32'(idx) << card_xfer_pkg::cmd_index_lsb) | 32'(m)
         | (32'(dat) << card_xfer_pkg::data_present_bit));
      run <= 1'b1;
      wait_flag(card_xfer_pkg::cmd_done_bit);
      chk({26'h0, idx_seen}, {26'h0, idx});
      chk(card_cmd_arg, arg);
   endtask : issue
   task automatic t_regs();
      apb(1'b0, card_xfer_pkg::host_ctrl_off, 32'h0);
      chk(q, card_xfer_pkg::reg_reset);
      apb(1'b0, card_xfer_pkg::present_off, 32'h0);
      chk(q, 32'(card_xfer_pkg::st_idle));
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'b1, card_xfer_pkg::host_ctrl_off, 32'h0002_0026);
      apb(1'b0, card_xfer_pkg::host_ctrl_off, 32'h0);
      chk(q, 32'h0002_0026);
      chk(host_ctrl, 32'h0002_0026);
   endtask : t_regs
   task automatic t_cmd();
      cmd_seen = 0;
      issue(6'd6, 16'h0, 1'b0, 32'h03B7_0100);
      chk(32'(cmd_seen), 32'h1);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, card_xfer_pkg::resp0_off + 8'(4 * i), 32'h0);
         chk(q, pat + 32'(i));
      end
   endtask : t_cmd
   task automatic t_write();
      wq.delete();
      issue(6'd23, 16'h0000, 1'b0, 32'h0000_0002);
      apb(1'b1, bk, 32'h0002_0008);
      issue(6'd25, mode(1'b0, 1'b1, 1'b0, 1'b1), 1'b1, 32'h0000_0040);
      rv_en <= 1'b0;
      for (int b = 0; b < 2; b++) begin
         wait_flag(card_xfer_pkg::wr_ready_bit);
         apb(1'b0, st, 32'h0);
         chk({31'h0, q[card_xfer_pkg::wr_ready_bit]}, 32'h0);
         for (int w = 0; w < 2; w++) apb(1'b1, bf, 32'h5A00_0000 + 32'(b*2+w));
      end
      wait_flag(card_xfer_pkg::xfer_done_bit);
      chk(32'(wq.size()), 32'h4);
      for (int i = 0; i < wq.size(); i++) begin
         chk(wq[i], 32'h5A00_0000 + 32'(i));
      end
      apb(1'b0, bk, 32'h0);
      chk(q, 32'h0000_0008);
   endtask : t_write
   task automatic t_read();
      apb(1'b1, bk, 32'h0001_0008);
      issue(6'd17, mode(1'b0, 1'b1, 1'b1, 1'b0), 1'b1, 32'h0000_0080);
      wait_flag(card_xfer_pkg::rd_ready_bit);
      apb(1'b0, bf, 32'h0);
      chk(q, pat + 32'h4);
      apb(1'b0, bf, 32'h0);
      chk(q, pat + 32'h5);
      wait_flag(card_xfer_pkg::xfer_done_bit);
   endtask : t_read
   task automatic t_sdma();
      wq.delete();
      apb(1'b1, bk, 32'h0002_0008);
      apb(1'b1, card_xfer_pkg::sys_addr_high_off, 32'h0000_0000);
      apb(1'b1, card_xfer_pkg::sys_addr_low_off, 32'h1000_0000);
      issue(6'd25, mode(1'b1, 1'b1, 1'b0, 1'b1), 1'b1, 32'h0000_00C0);
      rv_en <= 1'b0;
      wait_flag(card_xfer_pkg::dma_int_bit);
      repeat (40) @(posedge ref_clk);
      apb(1'b0, st, 32'h0);
      chk({31'h0, q[card_xfer_pkg::xfer_done_bit]}, 32'h0);
      chk(32'(wq.size()), 32'h2);
      apb(1'b1, card_xfer_pkg::sys_addr_low_off, 32'h1000_0008);
      wait_flag(card_xfer_pkg::xfer_done_bit);
      chk(32'(wq.size()), 32'h4);
   endtask : t_sdma
   // Descriptor DMA read: no count step, no stops, no ready flags
   task automatic t_adma();
      apb(1'b1, card_xfer_pkg::host_ctrl_off, 32'h0002_0036);
      apb(1'b1, card_xfer_pkg::sys_addr_low_off, 32'h2000_0000);
      apb(1'b1, bk, 32'h0002_0008);
      issue(6'd18, mode(1'b1, 1'b0, 1'b1, 1'b1), 1'b1, 32'h100);
      wait_flag(card_xfer_pkg::xfer_done_bit);
      apb(1'b0, st, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, bk, 32'h0);
      chk(q, 32'h0002_0008);
      apb(1'b0, bf, 32'h0);
      chk(q, pat + 32'h6);
      apb(1'b1, card_xfer_pkg::host_ctrl_off, 32'h0002_003E);
      apb(1'b1, card_xfer_pkg::id_addr_low_off, 32'h3000_0000);
      apb(1'b1, card_xfer_pkg::id_addr_high_off, 32'h0000_0001);
      apb(1'b0, card_xfer_pkg::id_addr_low_off, 32'h0);
      chk(q, 32'h3000_0000);
      apb(1'b0, card_xfer_pkg::id_addr_high_off, 32'h0);
      chk(q, 32'h0000_0001);
      chk(host_ctrl, 32'h0002_003E);
   endtask : t_adma
   initial begin
      ref_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      run = 1'b0; restart = 1'b0; rv_en = 1'b0;
      err_total = 0; n_checks = 0; cycles = 0; cmd_seen = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_cmd();
      t_write();
      t_read();
      t_sdma();
      t_adma();
      finish_test();
   end
endmodule : card_xfer_tb
`default_nettype wire
